// *** lwm_pkg.sv ***
// lwm_pkg: constants for the wake, mode and fail-safe control block.
// assumes a single 200 MHz clock; all times are held in ns and turned
// into cycle counts here, rounded up because every period is a minimum.
package lwm_pkg;

	localparam int unsigned CLK_MHZ = 200;

	// filter and timeout periods in ns
	localparam int unsigned BUS_WAKE_NS     = 50000;
	localparam int unsigned LOCAL_WAKE_NS   = 50000;
	localparam int unsigned NORMAL_ENTRY_NS = 10000;
	localparam int unsigned SLEEP_ENTRY_NS  = 10000;
	localparam int unsigned TX_DOM_NS       = 27000;

	localparam int unsigned BUS_WAKE_CYC     = (BUS_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned LOCAL_WAKE_CYC   = (LOCAL_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned NORMAL_ENTRY_CYC = (NORMAL_ENTRY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TX_DOM_CYC       = (TX_DOM_NS * CLK_MHZ + 999) / 1000;

	localparam int CNT_W = 32;

	typedef enum logic [1:0] {
		MODE_POWER_ON,
		MODE_SLEEP,
		MODE_STANDBY,
		MODE_NORMAL
	} lwm_mode_t;

endpackage

// *** lwm_mode_control.sv ***
// lwm_mode_control: wake detection, operating mode and driver fail-safe.
// inputs are synchronous to clk; analog comparators (temperature, supply,
// battery presence) arrive as clean levels; pin pull-ups and pull-downs
// are outside, this logic only decides when to enable them.
`timescale 1ns/1ps
`default_nettype none

module lwm_mode_control #(
	parameter int unsigned BUS_WAKE_CYC     = lwm_pkg::BUS_WAKE_CYC,
	parameter int unsigned LOCAL_WAKE_CYC   = lwm_pkg::LOCAL_WAKE_CYC,
	parameter int unsigned NORMAL_ENTRY_CYC = lwm_pkg::NORMAL_ENTRY_CYC,
	parameter int unsigned SLEEP_ENTRY_CYC  = lwm_pkg::SLEEP_ENTRY_CYC,
	parameter int unsigned TX_DOM_CYC       = lwm_pkg::TX_DOM_CYC
) (
	// clock, reset, enable
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          clk_en,
	// host side
	input  wire logic          tx_in,
	output logic               tx_pin_out,
	output logic               tx_pin_oe,
	output logic               rx_out,
	output logic               rx_oe,
	input  wire logic          sleep_control_n,
	// bus and local wake
	input  wire logic          bus_rx,
	output logic               bus_drive_dominant,
	output logic               termination_on,
	input  wire logic          local_wake_n,
	output logic               regulator_enable_out,
	// supply and temperature monitors
	input  wire logic          battery_ok,
	input  wire logic          thermal_shutdown_limit,
	input  wire logic          supply_low_threshold,
	input  wire logic          supply_recover_threshold,
	// status
	output lwm_pkg::lwm_mode_t mode,
	output logic               wake_source_local,
	output logic               wake_request,
	output logic               tx_timeout
);

	// full-width counters: narrower ones would save area but could silently
	// clip a long period handed in through the parameters
	localparam int W = lwm_pkg::CNT_W;

	// previous input levels for edge detection
	// transmit and sleep-control reset low, so a high pin gives one false
	// rising edge after reset; it only clears flags that are already clear
	logic tx_q;
	logic bus_q;
	logic lwake_q;
	logic slp_q;

	logic [W-1:0] bus_cnt;
	logic [W-1:0] lwake_cnt;
	logic [W-1:0] norm_cnt;
	logic [W-1:0] sleep_cnt;
	logic [W-1:0] tx_cnt;
	logic         bus_armed;
	logic         bus_qualified;
	logic         lwake_armed;
	logic         thermal_off;
	logic         supply_off;
	logic         drv_on;

	// saturating count toward a limit
	function automatic logic [W-1:0] sat_inc(input logic [W-1:0] c, input int unsigned lim);
		sat_inc = (c >= W'(lim)) ? c : c + W'(1);
	endfunction

	wire in_sleep   = (mode == lwm_pkg::MODE_SLEEP);
	wire in_standby = (mode == lwm_pkg::MODE_STANDBY);
	wire in_normal  = (mode == lwm_pkg::MODE_NORMAL);

	wire tx_fall    = tx_q & ~tx_in;
	wire tx_rise    = ~tx_q & tx_in;
	wire bus_fall   = bus_q & ~bus_rx;
	wire bus_rise   = ~bus_q & bus_rx;
	wire lwake_fall = lwake_q & ~local_wake_n;
	wire slp_rise   = ~slp_q & sleep_control_n;

	// dominant time only counted in these conditions
	wire bus_timing = in_sleep | (in_normal & tx_in);

	// rising edge closes a qualified dominant phase
	wire remote_wake = bus_armed & bus_rise & (bus_qualified | bus_cnt >= W'(BUS_WAKE_CYC));

	// low held long enough after a falling edge
	wire local_wake = lwake_armed & ~local_wake_n & (lwake_cnt + W'(1) >= W'(LOCAL_WAKE_CYC));

	// wakes only count where the device is not in Normal
	wire any_wake = (remote_wake | local_wake) & ~in_normal;

	// an undriven sleep-control reads low, which walks toward Sleep
	wire norm_done  = sleep_control_n & (norm_cnt + W'(1) >= W'(NORMAL_ENTRY_CYC));
	wire sleep_done = ~sleep_control_n & (sleep_cnt + W'(1) >= W'(SLEEP_ENTRY_CYC));

	// timeout reached while transmit still low
	wire tx_expire = ~tx_in & ~tx_rise & (tx_cnt + W'(1) >= W'(TX_DOM_CYC));

	// latches take the raw indication every cycle, so even a one-cycle fault
	// pulse blocks the driver until its release condition is met
	// thermal latch releases only with transmit recessive
	wire next_thermal_off = thermal_shutdown_limit | (thermal_off & ~tx_in);

	// supply latch needs recovery threshold and transmit recessive
	wire next_supply_off = supply_low_threshold |
		(supply_off & ~(supply_recover_threshold & tx_in));

	// an undriven transmit input reads low and is taken as a request
	wire next_bus_dom = in_normal & ~tx_in & drv_on & ~tx_timeout &
		~next_thermal_off & ~next_supply_off;

	// set wins over the clear in the same cycle
	wire next_wake_req = any_wake | (wake_request & ~slp_rise);

	// local sets, remote leaves it clear; cleared by sleep-control edge
	wire next_src_local = (any_wake & local_wake) | (wake_source_local & ~slp_rise);

	// mode sequencing
	lwm_pkg::lwm_mode_t next_mode;
	always_comb begin
		next_mode = mode;
		case (mode)
			lwm_pkg::MODE_POWER_ON: begin
				if (norm_done)
					next_mode = lwm_pkg::MODE_NORMAL;
			end
			lwm_pkg::MODE_SLEEP: begin
				if (norm_done)
					next_mode = lwm_pkg::MODE_NORMAL;
				else if (any_wake)
					next_mode = lwm_pkg::MODE_STANDBY;
			end
			lwm_pkg::MODE_STANDBY: begin
				if (norm_done)
					next_mode = lwm_pkg::MODE_NORMAL;
			end
			lwm_pkg::MODE_NORMAL: begin
				if (sleep_done)
					next_mode = lwm_pkg::MODE_SLEEP;
			end
			default: next_mode = lwm_pkg::MODE_SLEEP;
		endcase
		// loss of battery drops the device into Sleep
		if (!battery_ok)
			next_mode = lwm_pkg::MODE_SLEEP;
	end

	// regulator up in every mode but Sleep
	// sleep-control high from Sleep raises it before Normal is reached
	wire next_reg_en = (next_mode != lwm_pkg::MODE_SLEEP) | (in_sleep & sleep_control_n);

	// pending wake pulls receive low; Normal passes the bus through
	wire next_rx = in_normal ? bus_rx : ~next_wake_req;

	// outside Normal, released rather than driven high, so the host pull-up sets the idle level
	// receive floats when the battery is lost or nothing to say
	wire next_rx_oe = battery_ok & (in_normal | next_wake_req);

	// strong pull-down on the transmit pin for a local wake in Standby
	wire next_tx_oe = (next_mode == lwm_pkg::MODE_STANDBY) & next_src_local & battery_ok;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_q    <= 1'b0;
			bus_q   <= 1'b1;
			lwake_q <= 1'b1;
			slp_q   <= 1'b0;
		end else if (clk_en) begin
			tx_q    <= tx_in;
			bus_q   <= bus_rx;
			lwake_q <= local_wake_n;
			slp_q   <= sleep_control_n;
		end
	end

	// bus wake filter
	// count saturates at the limit, so a very long dominant phase cannot wrap
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus_armed     <= 1'b0;
			bus_qualified <= 1'b0;
			bus_cnt       <= '0;
		end else if (clk_en) begin
			// arm on the falling edge, drop arming on rising edge
			if (bus_fall) begin
				bus_armed     <= 1'b1;
				bus_qualified <= 1'b0;
				bus_cnt       <= '0;
			end else if (bus_rise) begin
				bus_armed     <= 1'b0;
				bus_qualified <= 1'b0;
				bus_cnt       <= '0;
			end else if (bus_armed & bus_timing) begin
				// count holds while timing is suspended
				bus_cnt <= sat_inc(bus_cnt, BUS_WAKE_CYC);
				if (bus_cnt >= W'(BUS_WAKE_CYC))
					bus_qualified <= 1'b1;
			end
		end
	end

	// local wake filter; fires once per falling edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lwake_armed <= 1'b0;
			lwake_cnt   <= '0;
		end else if (clk_en) begin
			// restart on each falling edge, abandon on release
			if (lwake_fall) begin
				lwake_armed <= 1'b1;
				lwake_cnt   <= '0;
			end else if (local_wake_n | local_wake) begin
				lwake_armed <= 1'b0;
				lwake_cnt   <= '0;
			end else if (lwake_armed) begin
				lwake_cnt <= sat_inc(lwake_cnt, LOCAL_WAKE_CYC);
			end
		end
	end

	// sleep-control hold timers; each restarts when the level flips
	// the low hold only runs in Normal: Standby and Power-on ignore a low pin
	always_ff @(posedge clk) begin
		if (!resetn) begin
			norm_cnt  <= '0;
			sleep_cnt <= '0;
		end else if (clk_en) begin
			norm_cnt  <= (sleep_control_n & ~in_normal) ?
				sat_inc(norm_cnt, NORMAL_ENTRY_CYC) : '0;
			// low-level hold, only meaningful from Normal
			sleep_cnt <= (~sleep_control_n & in_normal) ?
				sat_inc(sleep_cnt, SLEEP_ENTRY_CYC) : '0;
		end
	end

	// transmit dominant timeout
	// saturating count keeps the timeout latched however long transmit stays low
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_cnt     <= '0;
			tx_timeout <= 1'b0;
		end else if (clk_en) begin
			// falling edge starts, rising edge resets
			if (tx_fall | tx_rise | tx_in)
				tx_cnt <= '0;
			else
				tx_cnt <= sat_inc(tx_cnt, TX_DOM_CYC);
			if (tx_rise)
				tx_timeout <= 1'b0;
			else if (tx_expire)
				tx_timeout <= 1'b1;
		end
	end

	// mode, flags and outputs
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode                 <= lwm_pkg::MODE_POWER_ON;
			wake_request         <= 1'b0;
			wake_source_local    <= 1'b0;
			thermal_off          <= 1'b0;
			supply_off           <= 1'b0;
			drv_on               <= 1'b0;
			bus_drive_dominant   <= 1'b0;
			regulator_enable_out <= 1'b1;
			termination_on       <= 1'b1;
			rx_out               <= 1'b1;
			rx_oe                <= 1'b0;
			tx_pin_out           <= 1'b0;
			tx_pin_oe            <= 1'b0;
		end else if (clk_en) begin
			mode              <= next_mode;
			wake_request      <= next_wake_req;
			wake_source_local <= next_src_local;
			thermal_off       <= next_thermal_off;
			supply_off        <= next_supply_off;
			// transmitter stays off after Normal entry until transmit goes high
			drv_on            <= in_normal & (drv_on | tx_in);
			bus_drive_dominant   <= next_bus_dom;
			// regulator and termination follow the same wake state
			regulator_enable_out <= next_reg_en;
			termination_on       <= next_reg_en;
			rx_out               <= next_rx;
			rx_oe                <= next_rx_oe;
			tx_pin_out           <= 1'b0;
			tx_pin_oe            <= next_tx_oe;
		end
	end

endmodule

`default_nettype wire

// *** lwm_checker.sv ***
// lwm_checker: timing relations at the ports of lwm_mode_control.
// assumes clk_en stays high, so every clock edge is a counted sample.
`timescale 1ns/1ps
`default_nettype none

module lwm_checker #(
	parameter int unsigned TX_DOM_CYC       = 4,
	parameter int unsigned NORMAL_ENTRY_CYC = 4,
	parameter int unsigned SLEEP_ENTRY_CYC  = 4
) (
	// clock and reset
	input wire logic               clk,
	input wire logic               resetn,
	// inputs watched
	input wire logic               tx_in,
	input wire logic               sleep_control_n,
	input wire logic               bus_rx,
	input wire logic               local_wake_n,
	input wire logic               battery_ok,
	input wire logic               thermal_shutdown_limit,
	input wire logic               supply_low_threshold,
	// outputs watched
	input wire logic               tx_pin_out,
	input wire logic               tx_pin_oe,
	input wire logic               rx_out,
	input wire logic               rx_oe,
	input wire logic               bus_drive_dominant,
	input wire logic               termination_on,
	input wire logic               regulator_enable_out,
	input wire logic               wake_source_local,
	input wire logic               wake_request,
	input wire logic               tx_timeout,
	input wire lwm_pkg::lwm_mode_t mode
);
	// long holds are counted here rather than unrolled in a repetition
	int   txl;
	int   sch;
	int   scl;
	logic txp;

	always_ff @(posedge clk) begin
		txp <= tx_in;
		if (!resetn) begin
			txl <= 0;
			sch <= 0;
			scl <= 0;
		end else begin
			txl <= (!tx_in && mode == lwm_pkg::MODE_NORMAL && (txp || txl > 0)) ? txl + 1 : 0;
			sch <= (sleep_control_n && battery_ok) ? sch + 1 : 0;
			scl <= sleep_control_n ? 0 : scl + 1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	timeout_set_a: assert property (txl > TX_DOM_CYC |-> tx_timeout)
		else $error("dominant timeout missed");
	timeout_clear_a: assert property ($rose(tx_in) |=> !tx_timeout)
		else $error("timeout kept after tx rise");
	drive_cause_a: assert property (bus_drive_dominant |-> !$past(tx_in))
		else $error("bus driven without tx low");
	fault_off_a: assert property (
		(thermal_shutdown_limit || supply_low_threshold) [*2] |=> !bus_drive_dominant)
		else $error("bus driven during fault");
	flag_pair_a: assert property (wake_source_local |-> wake_request)
		else $error("source flag without wake");
	ack_clear_a: assert property (
		$rose(sleep_control_n) && local_wake_n && $stable(bus_rx)
		|=> !wake_request && !wake_source_local)
		else $error("wake flags kept after ack");
	wake_irq_a: assert property (wake_request && $past(battery_ok) |-> rx_oe && !rx_out)
		else $error("wake not shown on receive");
	source_pin_a: assert property (
		tx_pin_oe |-> wake_source_local && !tx_pin_out && mode == lwm_pkg::MODE_STANDBY)
		else $error("strong pull-down out of place");
	float_a: assert property (!battery_ok |=> !rx_oe)
		else $error("receive driven without battery");
	reg_on_a: assert property (
		mode != lwm_pkg::MODE_SLEEP |-> regulator_enable_out && termination_on)
		else $error("regulator off while awake");
	normal_entry_a: assert property (sch >= NORMAL_ENTRY_CYC |-> mode == lwm_pkg::MODE_NORMAL)
		else $error("normal entry late");
	sleep_entry_a: assert property (scl >= SLEEP_ENTRY_CYC |-> mode != lwm_pkg::MODE_NORMAL)
		else $error("sleep entry late");
endmodule

bind lwm_mode_control lwm_checker #(
	.TX_DOM_CYC(TX_DOM_CYC),
	.NORMAL_ENTRY_CYC(NORMAL_ENTRY_CYC),
	.SLEEP_ENTRY_CYC(SLEEP_ENTRY_CYC)
) u_chk (.clk, .resetn, .tx_in, .sleep_control_n, .bus_rx, .local_wake_n, .battery_ok,
	.thermal_shutdown_limit, .supply_low_threshold, .tx_pin_out, .tx_pin_oe, .rx_out,
	.rx_oe, .bus_drive_dominant, .termination_on, .regulator_enable_out,
	.wake_source_local, .wake_request, .tx_timeout, .mode);
`default_nettype wire

// *** lwm_host_model.sv ***
// lwm_host_model: host controller on the transmit, receive and sleep pins.
// assumes the bench steers it with levels changed at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module lwm_host_model (
	// commands from the bench
	input wire logic powered,
	input wire logic want_normal,
	input wire logic tx_bit,
	// block pins
	output logic     tx_in,
	output logic     sleep_control_n,
	input wire logic tx_pin_out,
	input wire logic tx_pin_oe,
	input wire logic rx_out,
	input wire logic rx_oe,
	// levels as read through the host pull-ups
	output logic     rx_seen,
	output logic     tx_pin_seen
);
	// unpowered host pins
	// an unpowered host leaves both lines to the pull-downs
	assign tx_in = powered & tx_bit;
	assign sleep_control_n = powered & want_normal;
	assign rx_seen = rx_oe ? rx_out : 1'h1;
	assign tx_pin_seen = (tx_pin_oe & ~tx_pin_out) ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// *** lwm_mode_control_bench.sv ***
// lwm_mode_control_bench: self-checking bench for the wake and mode block.
// assumes the checker is bound in and the host model drives the host pins.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("MISMATCH %s expected %h seen %h", nm, e, g); \
	end \
end

module lwm_mode_control_bench;
	localparam int P_BUS = 8;
	localparam int P_LOC = 6;
	localparam int P_NRM = 5;
	localparam int P_SLP = 5;
	localparam int P_TXD = 10;

	logic               clk, resetn, bus_rx, local_wake_n, battery_ok;
	logic               thermal_shutdown_limit, supply_low_threshold, supply_recover_threshold;
	logic               powered, want_normal, tx_bit, last_low, tx_in, sleep_control_n;
	logic               tx_pin_out, tx_pin_oe, rx_out, rx_oe, rx_seen, tx_pin_seen;
	logic               bus_drive_dominant, termination_on, regulator_enable_out;
	logic               wake_source_local, wake_request, tx_timeout;
	lwm_pkg::lwm_mode_t mode;
	logic [31:0]        seed;
	int                 fail_count = 0;
	int                 n_compared = 0;

	lwm_mode_control #(.BUS_WAKE_CYC(P_BUS), .LOCAL_WAKE_CYC(P_LOC),
		.NORMAL_ENTRY_CYC(P_NRM), .SLEEP_ENTRY_CYC(P_SLP), .TX_DOM_CYC(P_TXD)
	) u_dut (.clk, .resetn, .clk_en(1'h1), .tx_in, .tx_pin_out, .tx_pin_oe, .rx_out, .rx_oe,
		.sleep_control_n, .bus_rx, .bus_drive_dominant, .termination_on, .local_wake_n,
		.regulator_enable_out, .battery_ok, .thermal_shutdown_limit, .supply_low_threshold,
		.supply_recover_threshold, .mode, .wake_source_local, .wake_request, .tx_timeout);

	lwm_host_model u_host (.powered, .want_normal, .tx_bit, .tx_in, .sleep_control_n,
		.tx_pin_out, .tx_pin_oe, .rx_out, .rx_oe, .rx_seen, .tx_pin_seen);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// wake filter length of the chosen source
	function automatic int fil(input logic loc);
		return loc ? P_LOC : P_BUS;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic summarize();
		if (fail_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		#(5 * 4000);
		fail_count++;
		summarize();
	end

	initial begin
		{resetn, thermal_shutdown_limit, supply_low_threshold, want_normal, last_low} = 5'h00;
		{bus_rx, local_wake_n, battery_ok, supply_recover_threshold, powered, tx_bit} = 6'h3F;
		seed = 32'h0000030E;
		cyc(8);
		resetn = 1'h1;
		cyc(1);
		`CHK("power-on reg", 1'h1, regulator_enable_out & termination_on)
		want_normal = 1'h1;
		cyc(P_NRM + 2);
		`CHK("to normal", lwm_pkg::MODE_NORMAL, mode)
		// never two low cycles in a row, so the timeout stays out of reach
		for (int i = 0; i < 300; i++) begin
			seed = xs(seed);
			tx_bit = seed[0] | last_low;
			last_low = ~tx_bit;
			bus_rx = seed[1];
			cyc(1);
			`CHK("rx follow", bus_rx, rx_seen)
			`CHK("drive", ~tx_bit, bus_drive_dominant)
		end
		`CHK("no wake in normal", lwm_pkg::MODE_NORMAL, mode)
		bus_rx = 1'h1;
		tx_bit = 1'h0;
		cyc(P_TXD + 2);
		`CHK("timeout", 2'h2, {tx_timeout, bus_drive_dominant})
		tx_bit = 1'h1;
		cyc(2);
		`CHK("timeout clear", 1'h0, tx_timeout)
		tx_bit = 1'h0;
		cyc(P_TXD - 2);
		`CHK("timer restart", 1'h1, bus_drive_dominant)
		for (int i = 0; i < 2; i++) begin
			tx_bit = 1'h1;
			cyc(1);
			thermal_shutdown_limit = (i == 0);
			supply_low_threshold = (i == 1);
			supply_recover_threshold = (i == 0);
			tx_bit = 1'h0;
			cyc(2);
			`CHK("fault off", 1'h0, bus_drive_dominant)
			{thermal_shutdown_limit, supply_low_threshold, supply_recover_threshold} = 3'h1;
			cyc(2);
			`CHK("held off", 1'h0, bus_drive_dominant)
			tx_bit = 1'h1;
			cyc(2);
			tx_bit = 1'h0;
			cyc(2);
			`CHK("back on", 1'h1, bus_drive_dominant)
		end
		tx_bit = 1'h1;
		// k[0] picks local or remote, k[1] a pulse past the filter;
		// remote pulses hold transmit low, which Sleep must not care about
		for (int k = 0; k < 4; k++) begin
			want_normal = 1'h0;
			cyc(P_SLP + 2);
			`CHK("sleep", {lwm_pkg::MODE_SLEEP, 1'h0}, {mode, regulator_enable_out})
			local_wake_n = ~k[0];
			bus_rx = k[0];
			tx_bit = k[0];
			cyc(k[1] ? fil(k[0]) + 2 : fil(k[0]) - 3);
			{local_wake_n, bus_rx, tx_bit} = 3'h7;
			cyc(2);
			`CHK("woken", k[1], wake_request)
			if (k[1]) begin
				`CHK("standby", lwm_pkg::MODE_STANDBY, mode)
				`CHK("source", k[0], wake_source_local)
				`CHK("tx pin", ~k[0], tx_pin_seen)
				`CHK("wake irq", 1'h0, rx_seen)
				`CHK("wake reg", 1'h1, regulator_enable_out & termination_on)
				want_normal = 1'h1;
				cyc(2);
				`CHK("ack", 4'h3, {wake_request, wake_source_local, rx_seen, tx_pin_seen})
				cyc(P_NRM);
				`CHK("normal", lwm_pkg::MODE_NORMAL, mode)
			end
		end
		// bus low across the drop from Normal to Sleep: Normal cycles count only
		// while transmit is high, so only the t = 1 pass collects a full filter
		for (int t = 0; t < 2; t++) begin
			tx_bit = t[0];
			bus_rx = 1'h0;
			cyc(3);
			want_normal = 1'h0;
			cyc(P_SLP + 2);
			bus_rx = 1'h1;
			cyc(2);
			`CHK("normal timing", t[0], wake_request)
			want_normal = 1'h1;
			cyc(P_NRM + 2);
		end
		want_normal = 1'h0;
		cyc(P_SLP + 2);
		want_normal = 1'h1;
		cyc(2);
		`CHK("sc reg", 1'h1, regulator_enable_out)
		cyc(P_NRM);
		`CHK("sc normal", lwm_pkg::MODE_NORMAL, mode)
		powered = 1'h0;
		cyc(P_SLP + 2);
		`CHK("host off", lwm_pkg::MODE_SLEEP, mode)
		powered = 1'h1;
		cyc(P_NRM + 2);
		`CHK("rx driven", 1'h1, rx_oe)
		battery_ok = 1'h0;
		cyc(2);
		`CHK("rx float", {lwm_pkg::MODE_SLEEP, 1'h0}, {mode, rx_oe})
		battery_ok = 1'h1;
		cyc(2);
		summarize();
	end
endmodule
`default_nettype wire
